// [logic/gpio_edge_interrupt_port.sv]
// Behaviour
// R1 - each port p pin has an enable bit where 0 masks its flag from the interrupt and 1 lets it through.
// R2 - a port p flag is set by an active edge on its pin, rising or falling as its polarity bit says.
// R3 - writing 1 to a port p flag bit clears it and writing 0 leaves it alone.
// R4 - the interrupt is requested while any flag is set together with its enable bit.
// R5 - a read of the port j data register returns the latch for output pins and the pin level otherwise.
// R6 - the port j input register always returns the sampled pin levels and ignores writes.
// R7 - port j pins 7 and 6 have direction bits, 0 for input and 1 for output.
// R8 - after a direction change the readback may be stale for up to two cycles because of the synchroniser; the pad register makes it up to three here.
// R9 - port j outputs have a drive strength bit, 0 full and 1 about a third, ignored for inputs.
// R10 - port j pull enable bits act only on inputs or wired-or outputs, never on push-pull outputs.
// R11 - a port j polarity bit of 0 selects falling edges and a pull-up.
// R12 - a port j polarity bit of 1 selects rising edges and a pull-down.
// R13 - port p polarity bits select falling edge with pull-up at 0 and rising edge with pull-down at 1.
// R14 - port j pins 7 and 6 each have an enable bit where 0 masks and 1 enables the edge interrupt.
// R15 - port j flags are set by the active edge and cleared by writing 1, writing 0 does nothing; only input pins set a flag here.
// R16 - edges come from consecutive synchronised samples and a new edge beats a clear in the same cycle.
// R17 - writes to the port j data register always update the latch, even while the pin is an input.
`timescale 1ns/100ps
module gpio_edge_interrupt_port (
	// clock and reset
	input  wire logic                    core_clk,
	input  wire logic                    reset,
	// register port
	input  wire gpio_edge_pkg::bus_req_t bus_req,
	output logic [7:0]                   rd_data_q,
	// port p pins, inputs only in this block
	input  wire logic [7:0]              pp_pin_in,
	output logic [7:0]                   pp_pull_up_q,
	// port j pins 7 and 6
	input  wire logic [1:0]              pj_pin_in,
	output gpio_edge_pkg::pj_pad_t       pj_pad_q,
	// interrupt request, level
	output logic                         irq_q
);
	import gpio_edge_pkg::*;

	// software registers
	logic [PP_W-1:0]   pp_pol_q;
	logic [PP_W-1:0]   pp_ien_q;
	logic [PP_W-1:0]   pp_ifl_q;
	logic [PP_W-1:0]   pp_ifl_d;
	logic [PJ_W-1:0]   pj_wom_q;
	logic [PJ_W-1:0]   pj_data_q;
	logic [PJ_W-1:0]   pj_dir_q;
	logic [PJ_W-1:0]   pj_rdr_q;
	logic [PJ_W-1:0]   pj_per_q;
	logic [PJ_W-1:0]   pj_pps_q;
	logic [PJ_W-1:0]   pj_ien_q;
	logic [PJ_W-1:0]   pj_ifl_q;
	logic [PJ_W-1:0]   pj_ifl_d;

	// synchroniser stages and previous sample
	logic [PP_W-1:0]   pp_s1_q;
	logic [PP_W-1:0]   pp_s2_q;
	logic [PP_W-1:0]   pp_prev_q;
	logic [PJ_W-1:0]   pj_s1_q;
	logic [PJ_W-1:0]   pj_s2_q;
	logic [PJ_W-1:0]   pj_prev_q;

	// write decode
	wire               wr_pp_pol  = bus_req.wr && (bus_req.addr == OFS_PP_POL);
	wire               wr_pp_ien  = bus_req.wr && (bus_req.addr == OFS_PP_IEN);
	wire               wr_pp_ifl  = bus_req.wr && (bus_req.addr == OFS_PP_IFL);
	wire               wr_pj_wom  = bus_req.wr && (bus_req.addr == OFS_PJ_WOM);
	wire               wr_pj_data = bus_req.wr && (bus_req.addr == OFS_PJ_DATA);
	wire               wr_pj_dir  = bus_req.wr && (bus_req.addr == OFS_PJ_DIR);
	wire               wr_pj_rdr  = bus_req.wr && (bus_req.addr == OFS_PJ_RDR);
	wire               wr_pj_per  = bus_req.wr && (bus_req.addr == OFS_PJ_PER);
	wire               wr_pj_pps  = bus_req.wr && (bus_req.addr == OFS_PJ_PPS);
	wire               wr_pj_ien  = bus_req.wr && (bus_req.addr == OFS_PJ_IEN);
	wire               wr_pj_ifl  = bus_req.wr && (bus_req.addr == OFS_PJ_IFL);
	wire [PJ_W-1:0]    wd_pj      = bus_req.wdata[PJ_HI:PJ_LO];

	// edge detection on synchronised samples, never on the first stage
	wire [PP_W-1:0]    pp_rise = pp_s2_q & ~pp_prev_q; // R16
	wire [PP_W-1:0]    pp_fall = ~pp_s2_q & pp_prev_q; // R16
	wire [PP_W-1:0]    pp_edge = (pp_pol_q & pp_rise) | (~pp_pol_q & pp_fall); // R2 R13
	wire [PJ_W-1:0]    pj_rise = pj_s2_q & ~pj_prev_q; // R16
	wire [PJ_W-1:0]    pj_fall = ~pj_s2_q & pj_prev_q; // R16
	// output pins see their own drive, so only input pins may raise a flag
	wire [PJ_W-1:0]    pj_edge = ~pj_dir_q & ((pj_pps_q & pj_rise) | (~pj_pps_q & pj_fall)); // R11 R12

	// flag update: the set term is or-ed last so an edge beats a clear
	wire [PP_W-1:0]    pp_clr = wr_pp_ifl ? bus_req.wdata : PP_REG_RESET; // R3
	wire [PJ_W-1:0]    pj_clr = wr_pj_ifl ? wd_pj : PJ_REG_RESET; // R15
	assign pp_ifl_d = (pp_ifl_q & ~pp_clr) | pp_edge; // R2 R3 R16
	assign pj_ifl_d = (pj_ifl_q & ~pj_clr) | pj_edge; // R15 R16

	// interrupt request from unmasked flags
	wire [PP_W-1:0]    pp_live = pp_ifl_q & pp_ien_q; // R1
	wire [PJ_W-1:0]    pj_live = pj_ifl_q & pj_ien_q; // R14
	wire               irq_d   = (|pp_live) | (|pj_live); // R4

	// read paths
	wire [PJ_W-1:0]    pj_rd_data = (pj_dir_q & pj_data_q) | (~pj_dir_q & pj_s2_q); // R5
	wire [PJ_LO-1:0]   pad_lo     = '0;
	wire [7:0]         rd_pj_data = {pj_rd_data, pad_lo};
	wire [7:0]         rd_pj_pin  = {pj_s2_q, pad_lo}; // R6
	wire [7:0]         rd_sel =
		(bus_req.addr == OFS_PP_POL)  ? pp_pol_q :
		(bus_req.addr == OFS_PP_IEN)  ? pp_ien_q :
		(bus_req.addr == OFS_PP_IFL)  ? pp_ifl_q :
		(bus_req.addr == OFS_PJ_WOM)  ? {pj_wom_q, pad_lo} :
		(bus_req.addr == OFS_PJ_DATA) ? rd_pj_data :
		(bus_req.addr == OFS_PJ_PIN)  ? rd_pj_pin :
		(bus_req.addr == OFS_PJ_DIR)  ? {pj_dir_q, pad_lo} :
		(bus_req.addr == OFS_PJ_RDR)  ? {pj_rdr_q, pad_lo} :
		(bus_req.addr == OFS_PJ_PER)  ? {pj_per_q, pad_lo} :
		(bus_req.addr == OFS_PJ_PPS)  ? {pj_pps_q, pad_lo} :
		(bus_req.addr == OFS_PJ_IEN)  ? {pj_ien_q, pad_lo} :
		(bus_req.addr == OFS_PJ_IFL)  ? {pj_ifl_q, pad_lo} :
		RD_DATA_RESET; // unmapped reads as zero
	// data stand only in the cycle after the read strobe
	wire [7:0]         rd_data_d = bus_req.rd ? rd_sel : RD_DATA_RESET;

	// pad control; a wired-or pin drives only its low level
	pj_pad_t           pj_pad_d;
	wire [PJ_W-1:0]    pj_drive = pj_dir_q & (~pj_wom_q | ~pj_data_q); // R7
	assign pj_pad_d.out           = pj_data_q; // R17
	assign pj_pad_d.oe_n          = ~pj_drive; // R7
	assign pj_pad_d.drive_reduced = pj_rdr_q & pj_dir_q; // R9
	assign pj_pad_d.pull_en       = pj_per_q & (~pj_dir_q | pj_wom_q); // R10
	assign pj_pad_d.pull_up       = ~pj_pps_q; // R11 R12
	wire [PP_W-1:0]    pp_pull_up_d = ~pp_pol_q; // R13

	// two-flop synchronisers; two of the three cycles of readback lag after a direction change come from here
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pp_s1_q   <= PP_REG_RESET;
			pp_s2_q   <= PP_REG_RESET;
			pp_prev_q <= PP_REG_RESET;
			pj_s1_q   <= PJ_REG_RESET;
			pj_s2_q   <= PJ_REG_RESET;
			pj_prev_q <= PJ_REG_RESET;
		end else begin
			pp_s1_q   <= pp_pin_in;
			pp_s2_q   <= pp_s1_q; // R8
			pp_prev_q <= pp_s2_q;
			pj_s1_q   <= pj_pin_in;
			pj_s2_q   <= pj_s1_q; // R8
			pj_prev_q <= pj_s2_q;
		end
	end

	// port p control registers
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pp_pol_q <= PP_REG_RESET;
			pp_ien_q <= PP_REG_RESET;
			pp_ifl_q <= PP_REG_RESET;
		end else begin
			if (wr_pp_pol) begin
				pp_pol_q <= bus_req.wdata; // R13
			end
			if (wr_pp_ien) begin
				pp_ien_q <= bus_req.wdata; // R1
			end
			pp_ifl_q <= pp_ifl_d;
		end
	end

	// port j configuration registers; the input register has no storage
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pj_wom_q  <= PJ_REG_RESET;
			pj_data_q <= PJ_REG_RESET;
			pj_dir_q  <= PJ_REG_RESET;
			pj_rdr_q  <= PJ_REG_RESET;
			pj_per_q  <= PJ_REG_RESET;
			pj_pps_q  <= PJ_REG_RESET;
		end else begin
			if (wr_pj_wom) begin
				pj_wom_q <= wd_pj;
			end
			if (wr_pj_data) begin
				pj_data_q <= wd_pj; // R17
			end
			if (wr_pj_dir) begin
				pj_dir_q <= wd_pj; // R7
			end
			if (wr_pj_rdr) begin
				pj_rdr_q <= wd_pj; // R9
			end
			if (wr_pj_per) begin
				pj_per_q <= wd_pj; // R10
			end
			if (wr_pj_pps) begin
				pj_pps_q <= wd_pj; // R11 R12
			end
		end
	end

	// port j interrupt registers
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pj_ien_q <= PJ_REG_RESET;
			pj_ifl_q <= PJ_REG_RESET;
		end else begin
			if (wr_pj_ien) begin
				pj_ien_q <= wd_pj; // R14
			end
			pj_ifl_q <= pj_ifl_d;
		end
	end

	// registered outputs; pads follow the registers one cycle later
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rd_data_q    <= RD_DATA_RESET;
			irq_q        <= 1'b0;
			pj_pad_q     <= PJ_PAD_RESET;
			pp_pull_up_q <= PP_PULL_UP_RESET;
		end else begin
			rd_data_q    <= rd_data_d;
			irq_q        <= irq_d; // R4
			pj_pad_q     <= pj_pad_d;
			pp_pull_up_q <= pp_pull_up_d;
		end
	end

	// checks on the driven behaviour
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	property p_irq_masked;
		(pp_ifl_q & pp_ien_q) == 8'h00 && (pj_ifl_q & pj_ien_q) == 2'h0 |=> !irq_q;
	endproperty
	a_irq_masked: assert property (p_irq_masked) else $error("irq raised with every flag masked"); // R1 R14

	property p_irq_raise;
		(|(pp_ifl_q & pp_ien_q)) || (|(pj_ifl_q & pj_ien_q)) |=> irq_q;
	endproperty
	a_irq_raise: assert property (p_irq_raise) else $error("enabled flag did not raise irq"); // R4

	property p_pp_edge_sets;
		$rose(pp_s2_q[0]) && pp_pol_q[0] |=> pp_ifl_q[0];
	endproperty
	a_pp_edge_sets: assert property (p_pp_edge_sets) else $error("rising edge did not set flag"); // R2 R13

	property p_pp_fall_sets;
		$fell(pp_s2_q[0]) && !pp_pol_q[0] |=> pp_ifl_q[0];
	endproperty
	a_pp_fall_sets: assert property (p_pp_fall_sets) else $error("falling edge did not set flag"); // R2 R13

	property p_pp_clear;
		wr_pp_ifl && bus_req.wdata[0] && !pp_edge[0] |=> !pp_ifl_q[0];
	endproperty
	a_pp_clear: assert property (p_pp_clear) else $error("write one did not clear flag"); // R3

	property p_pp_keep;
		wr_pp_ifl && !bus_req.wdata[0] && pp_ifl_q[0] |=> pp_ifl_q[0];
	endproperty
	a_pp_keep: assert property (p_pp_keep) else $error("write zero changed flag"); // R3

	property p_set_wins;
		wr_pj_ifl && wd_pj[1] && pj_edge[1] |=> pj_ifl_q[1];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("clear beat a new edge"); // R16 R15

	property p_pj_data_read;
		bus_req.rd && bus_req.addr == OFS_PJ_DATA |=>
			rd_data_q[PJ_HI:PJ_LO] == (($past(pj_dir_q) & $past(pj_data_q)) | (~$past(pj_dir_q) & $past(pj_s2_q)));
	endproperty
	a_pj_data_read: assert property (p_pj_data_read) else $error("data readback wrong"); // R5

	property p_pj_pin_read;
		bus_req.rd && bus_req.addr == OFS_PJ_PIN |=> rd_data_q == {$past(pj_s2_q), 6'h00};
	endproperty
	a_pj_pin_read: assert property (p_pj_pin_read) else $error("pin readback wrong"); // R6

	property p_pin_lag;
		$stable(pj_pin_in) [*4] |-> pj_s2_q == pj_pin_in;
	endproperty
	a_pin_lag: assert property (p_pin_lag) else $error("synchroniser lag is not two cycles"); // R8

	property p_drive;
		pj_dir_q[0] && !pj_wom_q[0] |=> !pj_pad_q.oe_n[0] && pj_pad_q.pull_en[0] == 1'b0;
	endproperty
	a_drive: assert property (p_drive) else $error("push-pull output not driven or pulled"); // R7 R10

	property p_weak_ignored;
		!pj_dir_q[1] |=> !pj_pad_q.drive_reduced[1] && pj_pad_q.oe_n[1];
	endproperty
	a_weak_ignored: assert property (p_weak_ignored) else $error("input pin driven or reduced"); // R9

	property p_pull_dir;
		pj_per_q[0] && !pj_dir_q[0] |=> pj_pad_q.pull_en[0] && pj_pad_q.pull_up[0] == !$past(pj_pps_q[0]);
	endproperty
	a_pull_dir: assert property (p_pull_dir) else $error("pull direction wrong"); // R11 R12

	property p_latch_input;
		wr_pj_data && !pj_dir_q[0] ##1 wr_pj_dir && wd_pj[0] && !wr_pj_data |=>
			##1 pj_pad_q.out[0] == $past(bus_req.wdata[PJ_LO], 3);
	endproperty
	a_latch_input: assert property (p_latch_input) else $error("latch lost while input"); // R17

	// register writes land in the cycle after the strobe
	property p_pp_ien_write;
		wr_pp_ien |=> pp_ien_q == $past(bus_req.wdata);
	endproperty
	a_pp_ien_write: assert property (p_pp_ien_write) else $error("port p enable write lost"); // R1

	property p_pj_ien_write;
		wr_pj_ien |=> pj_ien_q == $past(wd_pj);
	endproperty
	a_pj_ien_write: assert property (p_pj_ien_write) else $error("port j enable write lost"); // R14

	property p_pj_dir_write;
		wr_pj_dir |=> pj_dir_q == $past(wd_pj);
	endproperty
	a_pj_dir_write: assert property (p_pj_dir_write) else $error("direction write lost"); // R7

	// a flag only rises after a qualified edge, so a stray set from a glitch in decode shows here
	property p_pp_no_stray;
		pp_edge == 8'h00 |=> (pp_ifl_q & ~$past(pp_ifl_q)) == 8'h00;
	endproperty
	a_pp_no_stray: assert property (p_pp_no_stray) else $error("port p flag set without edge"); // R2 R13

	property p_pj_no_stray;
		pj_edge == 2'h0 |=> (pj_ifl_q & ~$past(pj_ifl_q)) == 2'h0;
	endproperty
	a_pj_no_stray: assert property (p_pj_no_stray) else $error("port j flag set without edge"); // R15

	property p_pj_out_no_flag;
		pj_dir_q[1] && !pj_ifl_q[1] |=> !pj_ifl_q[1];
	endproperty
	a_pj_out_no_flag: assert property (p_pj_out_no_flag) else $error("output pin raised a flag"); // R15

	property p_pj_fall_sets;
		$fell(pj_s2_q[1]) && !pj_pps_q[1] && !pj_dir_q[1] |=> pj_ifl_q[1];
	endproperty
	a_pj_fall_sets: assert property (p_pj_fall_sets) else $error("port j falling edge lost"); // R11 R15

	property p_pj_rise_sets;
		$rose(pj_s2_q[0]) && pj_pps_q[0] && !pj_dir_q[0] |=> pj_ifl_q[0];
	endproperty
	a_pj_rise_sets: assert property (p_pj_rise_sets) else $error("port j rising edge lost"); // R12 R15

	property p_pj_clear;
		wr_pj_ifl && wd_pj[1] && !pj_edge[1] |=> !pj_ifl_q[1];
	endproperty
	a_pj_clear: assert property (p_pj_clear) else $error("port j write one did not clear"); // R15

	property p_pj_keep;
		wr_pj_ifl && !wd_pj[0] && pj_ifl_q[0] |=> pj_ifl_q[0];
	endproperty
	a_pj_keep: assert property (p_pj_keep) else $error("port j write zero changed flag"); // R15

	property p_pj_flag_read;
		bus_req.rd && bus_req.addr == OFS_PJ_IFL |=> rd_data_q == {$past(pj_ifl_q), 6'h00};
	endproperty
	a_pj_flag_read: assert property (p_pj_flag_read) else $error("port j flag readback wrong"); // R15

	// read data is zero outside the cycle after a read strobe, so bus or-ing stays safe
	property p_rd_idle;
		!bus_req.rd |=> rd_data_q == RD_DATA_RESET;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle"); // R5 R6

	// pad controls follow their registers one cycle later
	property p_pp_pull;
		1'b1 |=> pp_pull_up_q == ~$past(pp_pol_q);
	endproperty
	a_pp_pull: assert property (p_pp_pull) else $error("port p pull select wrong"); // R13

	property p_pj_pull_up;
		1'b1 |=> pj_pad_q.pull_up == ~$past(pj_pps_q);
	endproperty
	a_pj_pull_up: assert property (p_pj_pull_up) else $error("port j pull select wrong"); // R11 R12

	property p_pj_out;
		1'b1 |=> pj_pad_q.out == $past(pj_data_q);
	endproperty
	a_pj_out: assert property (p_pj_out) else $error("pad latch does not follow data"); // R17

	property p_reduced;
		pj_dir_q[1] |=> pj_pad_q.drive_reduced[1] == $past(pj_rdr_q[1]);
	endproperty
	a_reduced: assert property (p_reduced) else $error("reduced drive not applied"); // R9

	// a wired-or pin at a high latch is released to its pull
	property p_wired_or;
		pj_dir_q[1] && pj_wom_q[1] && pj_data_q[1] |=>
			pj_pad_q.oe_n[1] && pj_pad_q.pull_en[1] == $past(pj_per_q[1]);
	endproperty
	a_wired_or: assert property (p_wired_or) else $error("wired-or high not released"); // R10

endmodule // gpio_edge_interrupt_port

// [shared/gpio_edge_pkg.sv]
package gpio_edge_pkg;

	// register port geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// register offsets on the plain register port
	localparam logic [7:0] OFS_PP_POL  = 8'h1d;
	localparam logic [7:0] OFS_PP_IEN  = 8'h1e;
	localparam logic [7:0] OFS_PP_IFL  = 8'h1f;
	localparam logic [7:0] OFS_PJ_WOM  = 8'h27;
	localparam logic [7:0] OFS_PJ_DATA = 8'h28;
	localparam logic [7:0] OFS_PJ_PIN  = 8'h29;
	localparam logic [7:0] OFS_PJ_DIR  = 8'h2a;
	localparam logic [7:0] OFS_PJ_RDR  = 8'h2b;
	localparam logic [7:0] OFS_PJ_PER  = 8'h2c;
	localparam logic [7:0] OFS_PJ_PPS  = 8'h2d;
	localparam logic [7:0] OFS_PJ_IEN  = 8'h2e;
	localparam logic [7:0] OFS_PJ_IFL  = 8'h2f;

	// field positions: port p uses all bits, port j only bits 7 and 6
	localparam int PP_W  = 8;
	localparam int PJ_W  = 2;
	localparam int PJ_HI = 7;
	localparam int PJ_LO = 6;

	// reset values
	localparam logic [7:0] PP_REG_RESET = 8'h00;
	localparam logic [1:0] PJ_REG_RESET = 2'h0;
	localparam logic [7:0] PP_PULL_UP_RESET = 8'hff;
	localparam logic [7:0] RD_DATA_RESET = 8'h00;

	// pin synchroniser depth; readback lags a direction change by this many cycles plus one for the pad register
	localparam int SYNC_STAGES = 2;

	// register port request, one cycle per access
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} bus_req_t;

	// port j pad controls, index 1 is pin 7, index 0 is pin 6
	typedef struct packed {
		logic [PJ_W-1:0] out;
		logic [PJ_W-1:0] oe_n;
		logic [PJ_W-1:0] drive_reduced;
		logic [PJ_W-1:0] pull_en;
		logic [PJ_W-1:0] pull_up;
	} pj_pad_t;

	localparam pj_pad_t PJ_PAD_RESET = '{out: 2'h0, oe_n: 2'h3, drive_reduced: 2'h0,
		pull_en: 2'h0, pull_up: 2'h3};

endpackage

// [tb/gpio_edge_interrupt_port_tb_top.sv]
`timescale 1ns/100ps
// self-checking bench: register port, pin edges, pad controls and interrupt
module gpio_edge_interrupt_port_tb_top;
	import gpio_edge_pkg::*;

	logic       core_clk;
	logic       reset;
	bus_req_t   bus_req;
	logic [7:0] rd_data_q;
	logic [7:0] pp_pull_up_q;
	logic [7:0] pp_pin_in;
	logic [1:0] pj_pin_in;
	pj_pad_t    pj_pad_q;
	logic       irq_q;
	logic [7:0] ext_pp;
	logic [1:0] ext_pj;
	logic [1:0] ext_pj_en;
	int         error_cnt;
	int         total_checks;
	int         seed;
	logic [7:0] v;
	logic [7:0] p;
	logic [7:0] e;
	logic [7:0] adr [8];

	gpio_edge_interrupt_port u_dut (.core_clk(core_clk), .reset(reset), .bus_req(bus_req), .rd_data_q(rd_data_q),
		.pp_pin_in(pp_pin_in), .pp_pull_up_q(pp_pull_up_q), .pj_pin_in(pj_pin_in), .pj_pad_q(pj_pad_q), .irq_q(irq_q));
	gpio_pin_model u_pins (.core_clk(core_clk), .ext_pp(ext_pp), .ext_pj(ext_pj), .ext_pj_en(ext_pj_en),
		.pj_pad(pj_pad_q), .pp_pin(pp_pin_in), .pj_pin(pj_pin_in));

	// clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// port j registers keep only pins 7 and 6
	function automatic logic [7:0] rmask(logic [7:0] a, logic [7:0] d);
		return (a >= 8'h27) ? (d & 8'hc0) : d;
	endfunction

	task automatic chk(logic [15:0] got, logic [15:0] exp, string what);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic cyc(int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge core_clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		bus_req <= '0;
	endtask

	// two writes with no gap between the strobes
	task automatic wr_pair(logic [7:0] a0, logic [7:0] d0, logic [7:0] a1, logic [7:0] d1);
		@(posedge core_clk);
		bus_req <= '{addr: a0, wdata: d0, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		bus_req <= '{addr: a1, wdata: d1, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		bus_req <= '0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rd(logic [7:0] a, logic [7:0] exp);
		@(posedge core_clk);
		bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		bus_req <= '0;
		#1;
		chk(rd_data_q, exp, "read");
	endtask

	task automatic finish_test();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// watchdog, far beyond the few hundred cycles the sequence needs
	initial begin
		#200000;
		error_cnt++;
		finish_test();
	end

	// main sequence
	initial begin
		seed = 54;
		error_cnt = 0;
		total_checks = 0;
		reset = 1'b1;
		bus_req = '0;
		ext_pp = 8'h00;
		ext_pj = 2'h0;
		ext_pj_en = 2'h3;
		adr = '{8'h1d, 8'h1e, 8'h27, 8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h2e};
		repeat (12) @(posedge core_clk);
		reset <= 1'b0;
		cyc(1);
		chk(pp_pull_up_q, PP_PULL_UP_RESET, "pull sel");
		chk(pj_pad_q, PJ_PAD_RESET, "pads");
		chk(irq_q, 1'b0, "irq");
		foreach (adr[i]) rd(adr[i], 8'h00);
		rd(8'h1f, 8'h00);
		rd(8'h2f, 8'h00);
		// read-only and unmapped places ignore writes
		wr(8'h29, 8'hff);
		wr(8'h00, 8'hff);
		rd(8'h29, 8'h00);
		rd(8'h00, 8'h00);
		// random write and readback of every read-write register except the port j data register
		foreach (adr[i]) begin
			v = 8'($random(seed));
			wr(adr[i], v);
			rd(adr[i], rmask(adr[i], v));
		end
		foreach (adr[i]) wr(adr[i], 8'h00);
		// port p: every pin with random polarity and mask, pins idle at the inactive level
		p = 8'($random(seed));
		e = 8'($random(seed));
		wr(8'h1d, p);
		wr(8'h1e, e);
		ext_pp <= ~p;
		cyc(5);
		chk(pp_pull_up_q, {8'h00, ~p}, "pull sel");
		wr(8'h1f, 8'hff);
		rd(8'h1f, 8'h00);
		for (int i = 0; i < 8; i++) begin
			@(posedge core_clk);
			ext_pp[i] <= p[i];
			cyc(5);
			chk(irq_q, e[i], "irq");
			rd(8'h1f, 8'h01 << i);
			wr(8'h1f, ~(8'h01 << i));
			rd(8'h1f, 8'h01 << i);
			wr(8'h1f, 8'h01 << i);
			cyc(2);
			chk(irq_q, 1'b0, "irq");
			rd(8'h1f, 8'h00);
			@(posedge core_clk);
			ext_pp[i] <= ~p[i];
			cyc(5);
		end
		// port j as input: both readbacks show the pins, latch still takes writes
		wr(8'h1e, 8'h00);
		v = 8'($random(seed));
		@(posedge core_clk);
		ext_pj <= v[7:6];
		wr(8'h28, 8'h80);
		cyc(3);
		rd(8'h28, {v[7:6], 6'h00});
		rd(8'h29, {v[7:6], 6'h00});
		wr(8'h2b, 8'hc0);
		wr(8'h2c, 8'hc0);
		wr(8'h2d, 8'h40);
		cyc(1);
		chk({pj_pad_q.drive_reduced, pj_pad_q.pull_en, pj_pad_q.pull_up}, 6'b00_11_10, "pads in");
		// push-pull outputs: latch drives, pulls off, reduced drive on
		@(posedge core_clk);
		ext_pj_en <= 2'h0;
		wr_pair(8'h28, 8'h80, 8'h2a, 8'hc0);
		cyc(3);
		chk({pj_pad_q.out, pj_pad_q.oe_n, pj_pad_q.drive_reduced, pj_pad_q.pull_en}, 8'b10_00_11_00, "pads");
		rd(8'h28, 8'h80);
		rd(8'h29, 8'h80);
		// wired-or: a high latch is left to the pull-up
		wr(8'h27, 8'hc0);
		cyc(3);
		chk({pj_pad_q.oe_n, pj_pad_q.pull_en}, 4'b10_11, "wired-or");
		rd(8'h29, 8'h80);
		wr(8'h27, 8'h00);
		// port j edges on inputs, one falling and one rising
		wr(8'h2a, 8'h00);
		@(posedge core_clk);
		ext_pj <= 2'b10;
		ext_pj_en <= 2'h3;
		cyc(5);
		wr(8'h2f, 8'hc0);
		wr(8'h2e, 8'h80);
		rd(8'h2f, 8'h00);
		@(posedge core_clk);
		ext_pj <= 2'b01;
		cyc(5);
		rd(8'h2f, 8'hc0);
		chk(irq_q, 1'b1, "irq");
		wr(8'h2f, 8'h80);
		cyc(2);
		chk(irq_q, 1'b0, "irq");
		rd(8'h2f, 8'h40);
		wr(8'h2f, 8'h40);
		rd(8'h2f, 8'h00);
		// a clear that meets a new falling edge on pin 7 in the same cycle loses
		@(posedge core_clk);
		ext_pj <= 2'b11;
		cyc(5);
		@(posedge core_clk);
		ext_pj <= 2'b01;
		@(posedge core_clk);
		wr(8'h2f, 8'h80);
		rd(8'h2f, 8'h80);
		chk(irq_q, 1'b1, "irq");
		wr(8'h2f, 8'h80);
		rd(8'h2f, 8'h00);
		finish_test();
	end
endmodule // gpio_edge_interrupt_port_tb_top

// [tb/gpio_pin_model.sv]
`timescale 1ns/100ps
// far-side pins; an undriven, unpulled port j pin floats to a level that flips every cycle
module gpio_pin_model (
	// clock
	input  wire logic                   core_clk,
	// far-side drive
	input  wire logic [7:0]             ext_pp,
	input  wire logic [1:0]             ext_pj,
	input  wire logic [1:0]             ext_pj_en,
	// device side
	input  wire gpio_edge_pkg::pj_pad_t pj_pad,
	output logic [7:0]                  pp_pin,
	output logic [1:0]                  pj_pin
);
	import gpio_edge_pkg::*;

	logic [1:0] last_q;

	// port p pull enables live elsewhere, so the far side always drives them
	assign pp_pin = ext_pp;

	// pad drive wins over the far side, then the selected pull, else float
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			if (!pj_pad.oe_n[i]) begin
				pj_pin[i] = pj_pad.out[i];
			end else if (ext_pj_en[i]) begin
				pj_pin[i] = ext_pj[i];
			end else if (pj_pad.pull_en[i]) begin
				pj_pin[i] = pj_pad.pull_up[i];
			end else begin
				pj_pin[i] = (last_q[i] === 1'b1) ? 1'b0 : 1'b1; // unknown start counts as low
			end
		end
	end

	// last settled level, so a floating pin never looks stable
	always_ff @(posedge core_clk) last_q <= pj_pin;
endmodule // gpio_pin_model
